// File: design/sub_swap_pkg.sv
// Purpose: Shared constants and types for the subtract and nibble-swap datapath.
// Assumes: One instruction issued per cycle by the decoder, file data read combinationally.
// Notes: Carry follows the borrow-inverted convention: carry set means no borrow.
package sub_swap_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 6;
  localparam int NIB_W = 4;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Operation select from the decoder
  typedef enum logic [3:0] {
    OP_NONE = 4'h1,
    OP_SBC = 4'h2,
    OP_SUB = 4'h4,
    OP_SUBI = 4'h8
  } op_e;

  // One issued instruction
  typedef struct packed {
    logic valid;
    logic [3:0] op;
    logic swap;
    logic dest;
    logic [5:0] addr;
    logic [7:0] literal;
  } instr_s;

  // Status flags
  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } flags_s;
endpackage

// File: design/sub_swap_alu.sv
// Purpose: Accumulator datapath for subtract, subtract-with-carry, immediate subtract and swap.
// Assumes: file_rdata is the content of instr.addr in the same cycle; one clock ref_clk.
// Notes: File writes are a registered strobe; the register file commits them on the next edge.
`timescale 1ns/1ns
module sub_swap_alu (
  input wire logic ref_clk, // Core instruction clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire sub_swap_pkg::instr_s instr, // Instruction from decoder
  input wire logic [sub_swap_pkg::DATA_W-1:0] file_rdata, // Addressed file register data
  output logic [sub_swap_pkg::DATA_W-1:0] accumulator, // Accumulator value
  output sub_swap_pkg::flags_s flags, // Carry, digit carry, zero
  output logic file_we, // File register write strobe
  output logic [sub_swap_pkg::ADDR_W-1:0] file_waddr, // File register write address
  output logic [sub_swap_pkg::DATA_W-1:0] file_wdata, // File register write data
  output logic done // One-cycle completion pulse
);
  import sub_swap_pkg::*;

  logic [DATA_W-1:0] acc_q;
  flags_s flags_q;
  logic we_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic done_q;

  logic [DATA_W-1:0] minuend;
  logic cin;
  logic [DATA_W:0] sum;
  logic [NIB_W:0] low_sum;
  logic [DATA_W-1:0] result;
  logic arith;
  logic to_file;

  // Minuend plus inverted accumulator plus carry-in gives the difference; carry out = no borrow
  always_comb begin
    minuend = file_rdata;
    cin = 1'b1;
    arith = instr.valid && !instr.swap && (instr.op != OP_NONE);
    unique case (instr.op)
      OP_SBC: cin = flags_q.carry;
      OP_SUB: cin = 1'b1;
      OP_SUBI: minuend = instr.literal;
      default: cin = 1'b1;
    endcase
    sum = {1'b0, minuend} + {1'b0, ~acc_q} + {8'h00, cin};
    low_sum = {1'b0, minuend[NIB_W-1:0]} + {1'b0, ~acc_q[NIB_W-1:0]} + {4'h0, cin};
    if (instr.swap) begin
      result = {file_rdata[NIB_W-1:0], file_rdata[DATA_W-1:NIB_W]};
    end else begin
      result = sum[DATA_W-1:0];
    end
    // Immediate form always targets the accumulator
    to_file = instr.valid && (instr.swap || instr.op != OP_SUBI) && instr.dest == DEST_FILE
      && (instr.swap || arith);
  end

  // Accumulator update; swap counts as an op even with op field idle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= ACC_RESET;
    end else if ((arith || (instr.valid && instr.swap)) && !to_file) begin
      acc_q <= result;
    end
  end

  // Flags change only for the subtract family; swap leaves them alone
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= '0;
    end else if (arith) begin
      flags_q.carry <= sum[DATA_W];
      flags_q.digit_carry_flag <= low_sum[NIB_W];
      flags_q.zero <= (result == 8'h00);
    end
  end

  // File write-back strobe, held one cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      we_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      done_q <= 1'b0;
    end else begin
      we_q <= to_file;
      waddr_q <= instr.addr;
      wdata_q <= result;
      done_q <= arith || (instr.valid && instr.swap);
    end
  end

  assign accumulator = acc_q;
  assign flags = flags_q;
  assign file_we = we_q;
  assign file_waddr = waddr_q;
  assign file_wdata = wdata_q;
  assign done = done_q;

  // Swap must not touch flags
  swap_flags_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && instr.swap && !arith |=> flags == $past(flags))
    else $error("flags changed on swap");
  // Immediate subtract lands in accumulator, never file
  subi_dest_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_SUBI
    |=> accumulator == $past(instr.literal) - $past(accumulator) && !file_we)
    else $error("immediate subtract wrong");
  // Subtract result and zero flag
  sub_result_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_SUB && instr.dest == DEST_ACC
    |=> accumulator == $past(file_rdata) - $past(accumulator)
    && flags.zero == (accumulator == 8'h00))
    else $error("subtract result wrong");
  // Subtract with carry borrows when carry clear
  sbc_result_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_SBC && instr.dest == DEST_FILE
    |=> file_we && file_wdata == 8'($past(file_rdata) - $past(accumulator)
    - {7'h00, !$past(flags.carry)}))
    else $error("subtract with carry wrong");
  // Swap file write-back on destination one
  file_dest_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && instr.swap && instr.dest == DEST_FILE
    |=> file_we && file_waddr == $past(instr.addr) && accumulator == $past(accumulator))
    else $error("file write-back missing");
  // Swap result
  swap_data_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && instr.swap && instr.dest == DEST_ACC
    |=> accumulator == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap data wrong");
  // Completion in one cycle
  one_cycle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && (instr.swap || instr.op != OP_NONE) |=> done)
    else $error("operation not done in one cycle");
  // Idle keeps state
  idle_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !instr.valid |=> !file_we && !done && $stable(accumulator))
    else $error("state moved while idle");

  // Subtract carry means no borrow: set when the file operand is not below the accumulator
  sub_carry_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_SUB
    |=> flags.carry == ($past(file_rdata) >= $past(accumulator)))
    else $error("subtract carry wrong");

  // Subtract digit carry follows the low nibble borrow
  sub_dc_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_SUB
    |=> flags.digit_carry_flag == ($past(file_rdata[3:0]) >= $past(accumulator[3:0])))
    else $error("subtract digit carry wrong");

  // Subtract to the file leaves the accumulator and writes the difference back
  sub_file_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_SUB && instr.dest == DEST_FILE
    |=> file_we && file_waddr == $past(instr.addr) && accumulator == $past(accumulator)
    && file_wdata == $past(file_rdata) - $past(accumulator))
    else $error("subtract write-back wrong");

  // Immediate subtract carry and zero come from literal against accumulator
  subi_flags_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_SUBI
    |=> flags.carry == ($past(instr.literal) >= $past(accumulator))
    && flags.zero == ($past(instr.literal) == $past(accumulator)))
    else $error("immediate subtract flags wrong");

  // Immediate subtract digit carry from the low nibbles
  subi_dc_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_SUBI
    |=> flags.digit_carry_flag == ($past(instr.literal[3:0]) >= $past(accumulator[3:0])))
    else $error("immediate digit carry wrong");

  // Subtract with carry into the accumulator, borrow taken when carry was clear
  sbc_acc_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_SBC && instr.dest == DEST_ACC
    |=> !file_we && accumulator == 8'($past(file_rdata) - $past(accumulator)
    - {7'h00, !$past(flags.carry)}))
    else $error("subtract with carry to accumulator wrong");

  // Subtract with carry: carry out set unless the chained borrow runs past zero
  sbc_carry_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_SBC
    |=> flags.carry == ({1'b0, $past(file_rdata)}
    >= {1'b0, $past(accumulator)} + {8'h00, !$past(flags.carry)}))
    else $error("subtract with carry flag wrong");

  // Subtract with carry zero flag tracks the full chained difference
  sbc_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_SBC
    |=> flags.zero == (8'($past(file_rdata) - $past(accumulator)
    - {7'h00, !$past(flags.carry)}) == 8'h00))
    else $error("subtract with carry zero wrong");

  // Subtract with carry to the file must not move the accumulator
  sbc_file_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_SBC && instr.dest == DEST_FILE
    |=> accumulator == $past(accumulator) && file_waddr == $past(instr.addr))
    else $error("subtract with carry moved accumulator");

  // Swap back to the file carries the exchanged nibbles
  swap_file_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && instr.swap && instr.dest == DEST_FILE
    |=> file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap write-back wrong");

  // Swap into the accumulator raises no file write
  swap_acc_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && instr.swap && instr.dest == DEST_ACC |=> !file_we)
    else $error("swap to accumulator wrote file");

  // Valid with no operation and no swap is refused outright
  op_refused_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_NONE
    |=> !done && !file_we && $stable(accumulator) && $stable(flags))
    else $error("refused operation changed state");

  // Done is only ever the echo of an accepted instruction one cycle back
  done_echo_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    done |-> $past(instr.valid))
    else $error("done without instruction");

  // A file write is always part of a completed operation
  write_done_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    file_we |-> done)
    else $error("file write without done");

  // Immediate subtract ignores the destination bit even when it is one
  subi_nofile_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    instr.valid && !instr.swap && instr.op == OP_SUBI && instr.dest == DEST_FILE
    |=> !file_we && done)
    else $error("immediate subtract wrote file");
endmodule

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the subtract and nibble-swap datapath.
// Assumes: done pulses one cycle after an instruction is taken.
// Notes: Expected values come from a bench model, never from design outputs.
`timescale 1ns/1ns
module tb_top;
  import sub_swap_pkg::*;
  typedef struct packed {
    logic [7:0] acc;
    flags_s fl;
    logic we;
    logic [5:0] wa;
    logic [7:0] wd;
  } note_s;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  instr_s instr = '0;
  logic [7:0] file_rdata = 8'h00;
  logic [7:0] accumulator;
  flags_s flags;
  logic file_we;
  logic [5:0] file_waddr;
  logic [7:0] file_wdata;
  logic done;
  note_s notes[$];
  note_s exp_n;
  note_s got_n;
  logic [7:0] acc_m = 8'h00;
  flags_s flg_m = '0;
  logic [31:0] seed = 32'hf581;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  sub_swap_alu sub_swap_alu_i (.ref_clk(ref_clk), .nrst(nrst), .instr(instr),
    .file_rdata(file_rdata), .accumulator(accumulator), .flags(flags),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata), .done(done));

  // Clock, 4 ns period
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic end_of_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Drive one instruction; refused ones leave no note, so a stray done is caught
  task automatic issue(input instr_s ins, input logic [7:0] fd);
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] a;
    logic [7:0] r;
    logic cin;
    logic w;
    @(posedge ref_clk);
    #1;
    instr = ins;
    file_rdata = fd;
    if (!ins.valid || (!ins.swap && ins.op == OP_NONE)) return;
    a = (ins.op == OP_SUBI) ? ins.literal : fd;
    cin = (ins.op == OP_SBC) ? flg_m.carry : 1'b1;
    sum = {1'b0, a} + {1'b0, ~acc_m} + 9'(cin);
    low = {1'b0, a[3:0]} + {1'b0, ~acc_m[3:0]} + 5'(cin);
    r = ins.swap ? {fd[3:0], fd[7:4]} : sum[7:0];
    if (!ins.swap) flg_m = '{sum[8], low[4], r == 8'h00};
    w = ins.dest && (ins.swap || ins.op != OP_SUBI);
    if (!w) acc_m = r;
    notes.push_back('{acc_m, flg_m, w, ins.addr, r});
  endtask

  // Watcher: settle after the edge, then match each done against the oldest note
  always @(posedge ref_clk) begin
    #2;
    cycles++;
    if (cycles > 3000) begin
      err_total++;
      end_of_test();
    end
    if (done === 1'b1) begin
      comparisons++;
      if (notes.size() == 0) begin
        err_total++;
        $display("unexpected done exp 0 got 1");
      end else begin
        exp_n = notes.pop_front();
        got_n = {accumulator, flags, file_we, file_waddr, file_wdata};
        if (!exp_n.we) got_n[13:0] = exp_n[13:0];
        if (got_n !== exp_n) begin
          err_total++;
          $display("unexpected result exp %h got %h", exp_n, got_n);
        end
      end
    end
  end

  // Reset, then random back-to-back traffic over all ops, both destinations
  initial begin
    instr_s ins;
    repeat (6) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    for (int i = 0; i < 600; i++) begin
      seed = xs(seed);
      ins = {seed[0] | seed[1], 4'h1 << seed[3:2], seed[4] & seed[5], seed[6],
        seed[12:7], seed[20:13]};
      issue(ins, seed[28:21]);
    end
    issue('0, 8'h00);
    repeat (3) @(posedge ref_clk);
    comparisons++;
    if (notes.size() != 0) begin
      err_total++;
      $display("unexpected pending exp 0 got %0d", notes.size());
    end
    end_of_test();
  end
endmodule
